/* srs_act_det.sv */
// Purpose: decides whether a slow clock input is toggling
// Assumes: lvl comes from a two-stage synchroniser in the caller
// Notes:   verdict holds after the window closes until clr
`timescale 1ns/1ps
module srs_act_det
    import srs_pkg::*;
#(
    parameter int MIN_EDGES = ACT_MIN_EDGES  // edges needed for a verdict
) (
    input  wire logic CLK,
    input  wire logic ARST_N,
    srs_act_if.det    act
);
    localparam int EW = $clog2(MIN_EDGES + 1);

    logic          prev_reg;     // last level, for edge detection
    logic          prev_next;
    logic [EW-1:0] edges_reg;    // saturating rising-edge count
    logic [EW-1:0] edges_next;
    logic          active_reg;   // verdict
    logic          active_next;

    // next-value logic: count rising edges only inside the window
    always_comb begin
        prev_next   = act.lvl;
        edges_next  = edges_reg;
        active_next = active_reg;
        if (act.clr) begin
            edges_next  = '0;
            active_next = 1'b0;
        end else if (act.win) begin
            // saturate so a fast clock cannot wrap the count
            if (act.lvl && !prev_reg && edges_reg != EW'(MIN_EDGES)) begin
                edges_next = edges_reg + EW'(1);
            end
            active_next = (edges_reg == EW'(MIN_EDGES));
        end
    end

    // registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prev_reg   <= 1'b0;
            edges_reg  <= '0;
            active_reg <= 1'b0;
        end else begin
            prev_reg   <= prev_next;
            edges_reg  <= edges_next;
            active_reg <= active_next;
        end
    end

    assign act.active = active_reg;
endmodule

/* srs_act_if.sv */
// Purpose: carrier between the sequencer and a clock activity detector
// Assumes: lvl is already synchronised to the core clock
// Notes:   one instance per watched clock
`timescale 1ns/1ps
interface srs_act_if;
    logic lvl;      // synchronised level of the watched clock
    logic win;      // detection window open
    logic clr;      // forget edges and verdict
    logic active;   // enough edges seen in the window
    modport det (input lvl, input win, input clr, output active);
    modport ctl (output lvl, output win, output clr, input active);
endinterface

/* srs_host_model.sv */
// Purpose: host side of the sequencer: reset pin, supply flag, outside clocks
// Assumes: bench sets the controls at the falling core clock edge
// Notes:   oscillators run free of the core clock, toggling midway between core clock edges
`timescale 1ns/1ps
module srs_host_model (
    input  wire logic pin_hold,    // hold the reset pin low
    input  wire logic supply_on,   // core supply above threshold
    input  wire logic ref_on,      // reference oscillator fitted
    input  wire logic slow_on,     // outside slow clock fitted
    output logic      reset_pin_n, // reset pin level
    output logic      supply_ok,   // supply flag level
    output logic      ref_osc,     // reference oscillator sample
    output logic      slow_clk     // outside slow clock
);
    // pin and supply follow the bench at once
    assign reset_pin_n = !pin_hold;
    assign supply_ok   = supply_on;
    // reference sample; parked low when absent so no rising edge is ever seen
    initial begin
        ref_osc = 1'b0;
        // offset keeps every toggle off both core clock edges
        #25;
        forever begin
            #650;
            ref_osc = ref_on ? !ref_osc : 1'b0;
        end
    end
    // slow clock; a slower period, kept off the core grid by the offset below
    initial begin
        slow_clk = 1'b0;
        // same offset, toggles never meet a core clock edge
        #25;
        forever begin
            #1850;
            slow_clk = slow_on ? !slow_clk : 1'b0;
        end
    end
endmodule

/* srs_pkg.sv */
// Purpose: shared constants for the startup and reset release sequencer
// Assumes: one 10 MHz core clock
// Notes:   times are kept in their printed unit, cycle counts are derived
package srs_pkg;
    // core clock
    localparam int CLK_PERIOD_NS   = 100;
    // power-up reset hold, typical and earliest release, in microseconds
    localparam int POR_TYP_US      = 3000;
    localparam int POR_MIN_US      = 1500;
    // delay from release to clock request, in microseconds
    localparam int CLKREQ_DLY_US   = 120;
    // least time spent asleep after release, in microseconds
    localparam int SLEEP_MIN_US    = 4200;
    // derived counts; the least times round up
    localparam int POR_TYP_CYC     = (POR_TYP_US * 1000) / CLK_PERIOD_NS;
    localparam int POR_MIN_CYC     = (POR_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLKREQ_CYC      = (CLKREQ_DLY_US * 1000) / CLK_PERIOD_NS;
    localparam int SLEEP_MIN_CYC   = (SLEEP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // width of the sequence counters
    localparam int CNT_W           = 16;
    // edges needed inside the window before a clock counts as running
    localparam int ACT_MIN_EDGES   = 4;
    // sequencer states
    typedef enum logic [1:0] {
        SRS_ST_HOLD  = 2'b00,   // global reset held
        SRS_ST_SLEEP = 2'b01,   // released, asleep, clocks settling
        SRS_ST_RUN   = 2'b10    // clocks chosen, boot may start
    } srs_state_t;
endpackage

/* srs_startup_seq.sv */
// Purpose: startup and reset release sequencer of the transceiver
// Assumes: CORE_SUPPLY_OK is high while the core supply is above 0.8 V
// Notes:   all pin inputs pass two flip-flops before any logic reads them
// Operation
// [RULE1] hold reset while pin or power-up reset
// [RULE2] power-up reset lasts 3 ms, never below 1.5
// [RULE3] start from pin reset or from power-up
// [RULE4] clock request about 120 us after release
// [RULE5] stay asleep at least 4.2 ms
// [RULE6] outside clocks stable by end of sleep
// [RULE7] no reference oscillator means crystal is used
// [RULE8] idle slow input means internal oscillator
// [RULE9] combined release synchronised to core clock
`timescale 1ns/1ps
module srs_startup_seq
    import srs_pkg::*;
#(
    parameter int POR_CYC   = POR_TYP_CYC,    // power-up reset hold in cycles
    parameter int SLEEP_CYC = SLEEP_MIN_CYC   // sleep length in cycles
) (
    input  wire logic CLK,
    input  wire logic ARST_N,
    input  wire logic RESET_PIN_N,
    input  wire logic CORE_SUPPLY_OK,
    input  wire logic REF_OSC_IN,
    input  wire logic SLOW_SLEEP_CLOCK_IN,
    output logic      CHIP_RST_N,
    output logic      CLK_REQ,
    output logic      SLEEP,
    output logic      BOOT_GO,
    output logic      USE_REF_OSC,
    output logic      CRYSTAL_EN,
    output logic      USE_EXT_SLOW_CLK
);
    logic [3:0]     sync1_reg;      // first stage, read only by sync2_reg
    logic [3:0]     sync2_reg;      // second stage: pin, supply, ref, slow
    logic           pin_ok;         // external reset released
    logic           supply_ok;      // core supply above threshold
    logic           por_reg;        // internal power-up reset asserted
    logic           por_next;
    logic [CNT_W-1:0] por_cnt_reg;  // time since supply came up
    logic [CNT_W-1:0] por_cnt_next;
    logic           rel_reg;        // combined release, on the core clock
    logic           rel_next;
    srs_state_t     state_reg;
    srs_state_t     state_next;
    logic [CNT_W-1:0] cnt_reg;      // time since release
    logic [CNT_W-1:0] cnt_next;
    logic           req_reg;        // clock request
    logic           req_next;
    logic           use_ref_reg;    // run from the outside oscillator
    logic           use_ref_next;
    logic           use_slow_reg;   // run from the outside slow clock
    logic           use_slow_next;
    logic           win;            // detection window during sleep

    srs_act_if ref_act ();
    srs_act_if slow_act ();

    // two-stage synchronisers for every pin input
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {SLOW_SLEEP_CLOCK_IN, REF_OSC_IN, CORE_SUPPLY_OK, RESET_PIN_N};
            sync2_reg <= sync1_reg;
        end
    end
    assign pin_ok    = sync2_reg[0];
    assign supply_ok = sync2_reg[1];

    // power-up reset: restarts whenever the supply dips
    always_comb begin
        por_next     = por_reg;
        por_cnt_next = por_cnt_reg;
        if (!supply_ok) begin
            por_next     = 1'b1;
            por_cnt_next = '0;
        end else if (por_reg) begin
            if (por_cnt_reg == CNT_W'(POR_CYC - 1)) begin
                por_next = 1'b0;                          // [RULE2]
            end else begin
                por_cnt_next = por_cnt_reg + CNT_W'(1);
            end
        end
    end

    // release only when the later of both resets lets go
    always_comb begin
        rel_next = pin_ok && !por_reg;                    // [RULE1] [RULE3]
    end

    // clock detection window covers the second half of sleep, where
    // outside clocks are promised to run
    assign win          = (state_reg == SRS_ST_SLEEP) &&
                          (cnt_reg >= CNT_W'(SLEEP_CYC / 2)); // [RULE6]
    assign ref_act.lvl  = sync2_reg[2];
    assign ref_act.win  = win;
    assign ref_act.clr  = (state_reg == SRS_ST_HOLD);
    assign slow_act.lvl = sync2_reg[3];
    assign slow_act.win = win;
    assign slow_act.clr = (state_reg == SRS_ST_HOLD);

    // sequence: hold, sleep with clock request, then run
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        req_next      = req_reg;
        use_ref_next  = use_ref_reg;
        use_slow_next = use_slow_reg;
        if (!rel_reg) begin
            // any reset pulls the whole sequence back
            state_next    = SRS_ST_HOLD;                  // [RULE1]
            cnt_next      = '0;
            req_next      = 1'b0;
            use_ref_next  = 1'b0;
            use_slow_next = 1'b0;
        end else begin
            unique case (state_reg)
                SRS_ST_HOLD: begin
                    state_next = SRS_ST_SLEEP;            // [RULE3]
                    cnt_next   = '0;
                end
                SRS_ST_SLEEP: begin
                    cnt_next = cnt_reg + CNT_W'(1);
                    if (cnt_reg == CNT_W'(CLKREQ_CYC - 1)) begin
                        req_next = 1'b1;                  // [RULE4]
                    end
                    if (cnt_reg == CNT_W'(SLEEP_CYC - 1)) begin
                        state_next    = SRS_ST_RUN;       // [RULE5]
                        use_ref_next  = ref_act.active;   // [RULE7]
                        use_slow_next = slow_act.active;  // [RULE8]
                    end
                end
                SRS_ST_RUN: begin
                    // hold choices until the next reset
                    state_next = SRS_ST_RUN;
                end
                default: begin
                    state_next = SRS_ST_HOLD;
                end
            endcase
        end
    end

    // registers; async reset forces constants only
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            por_reg      <= 1'b1;
            por_cnt_reg  <= '0;
            rel_reg      <= 1'b0;
            state_reg    <= SRS_ST_HOLD;
            cnt_reg      <= '0;
            req_reg      <= 1'b0;
            use_ref_reg  <= 1'b0;
            use_slow_reg <= 1'b0;
        end else begin
            por_reg      <= por_next;
            por_cnt_reg  <= por_cnt_next;
            rel_reg      <= rel_next;                     // [RULE9]
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            req_reg      <= req_next;
            use_ref_reg  <= use_ref_next;
            use_slow_reg <= use_slow_next;
        end
    end

    // detectors for the reference and the slow clock
    srs_act_det u_ref_det (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .act    (ref_act)
    );
    srs_act_det u_slow_det (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .act    (slow_act)
    );

    // outputs, all from flip-flops or their direct decode
    assign CHIP_RST_N       = rel_reg;
    assign CLK_REQ          = req_reg;
    assign SLEEP            = (state_reg == SRS_ST_SLEEP);
    assign BOOT_GO          = (state_reg == SRS_ST_RUN);
    assign USE_REF_OSC      = use_ref_reg;
    assign CRYSTAL_EN       = !use_ref_reg;
    assign USE_EXT_SLOW_CLK = use_slow_reg;

    // helper: cycles the supply has stood high, saturating
    logic [CNT_W-1:0] sup_run_reg;
    logic [CNT_W-1:0] sup_run_next;

    // helper next value; saturation keeps a long run from wrapping to zero
    always_comb begin
        sup_run_next = sup_run_reg;
        if (!supply_ok) begin
            sup_run_next = '0;
        end else if (sup_run_reg != '1) begin
            sup_run_next = sup_run_reg + CNT_W'(1);
        end
    end

    // helper register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sup_run_reg <= '0;
        end else begin
            sup_run_reg <= sup_run_next;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    AST_HOLD_ON_PIN: assert property ( // [RULE1]
        !pin_ok |=> !CHIP_RST_N ##1 (state_reg == SRS_ST_HOLD))
        else $error("sequence not held while pin reset asserted");
    AST_POR_LENGTH: assert property ( // [RULE2]
        $fell(por_reg) |-> sup_run_reg >= CNT_W'(POR_CYC))
        else $error("power-up reset released too early");
    AST_RELEASE_SYNC: assert property ( // [RULE9]
        $rose(rel_reg) |-> $past(pin_ok) && !$past(por_reg))
        else $error("release without both resets gone");
    AST_POR_BLOCKS: assert property ( // [RULE3]
        por_reg |=> !rel_reg)
        else $error("released during power-up reset");
    AST_CLKREQ_TIME: assert property ( // [RULE4]
        $rose(req_reg) |-> cnt_reg == CNT_W'(CLKREQ_CYC) && SLEEP)
        else $error("clock request at wrong time");
    AST_NO_REQ_IN_HOLD: assert property ( // [RULE4]
        state_reg == SRS_ST_HOLD |-> !CLK_REQ)
        else $error("clock request while in reset");
    AST_SLEEP_MIN: assert property ( // [RULE5]
        $rose(BOOT_GO) |-> $past(cnt_reg) == CNT_W'(SLEEP_CYC - 1))
        else $error("sleep left too early");
    AST_XTAL_DEFAULT: assert property ( // [RULE7]
        $rose(BOOT_GO) |-> USE_REF_OSC == $past(ref_act.active) &&
                           CRYSTAL_EN == !USE_REF_OSC)
        else $error("crystal not used without reference");
    AST_SLOW_FALLBACK: assert property ( // [RULE8]
        $rose(BOOT_GO) |-> USE_EXT_SLOW_CLK == $past(slow_act.active))
        else $error("slow clock choice does not follow activity");

    COV_PIN_PATH: cover property ($rose(pin_ok) ##[1:4] $rose(rel_reg));
    COV_POR_PATH: cover property ($fell(por_reg) ##[1:4] $rose(rel_reg));
    COV_EXT_SLOW: cover property ($rose(BOOT_GO) && USE_EXT_SLOW_CLK);
    COV_CRYSTAL:  cover property ($rose(BOOT_GO) && CRYSTAL_EN);
endmodule

/* tb_srs_startup_seq.sv */
// Purpose: self-checking bench for the startup and reset release sequencer
// Assumes: shortened power-up and sleep counts through the parameters
// Notes:   all waits are bounded; a hang ends in the watchdog
`timescale 1ns/1ps
module tb_srs_startup_seq;
    import srs_pkg::*;
    localparam int POR_T   = 50;   // shortened power-up hold
    localparam int SLEEP_T = 2600; // shortened sleep, above the request delay
    logic clk, arst_n, pin_hold, supply_on, ref_on, slow_on;
    logic rst_pin_n, sup_ok, ref_osc, slow_clk;
    logic chip_rst_n, clk_req, sleep, boot_go, use_ref, xtal_en, use_slow;
    int   error_cnt, total_checks, n;
    // partner and device
    srs_host_model HOST (.pin_hold(pin_hold), .supply_on(supply_on), .ref_on(ref_on),
        .slow_on(slow_on), .reset_pin_n(rst_pin_n), .supply_ok(sup_ok),
        .ref_osc(ref_osc), .slow_clk(slow_clk));
    srs_startup_seq #(.POR_CYC(POR_T), .SLEEP_CYC(SLEEP_T)) DUT (.CLK(clk), .ARST_N(arst_n),
        .RESET_PIN_N(rst_pin_n), .CORE_SUPPLY_OK(sup_ok), .REF_OSC_IN(ref_osc),
        .SLOW_SLEEP_CLOCK_IN(slow_clk), .CHIP_RST_N(chip_rst_n), .CLK_REQ(clk_req),
        .SLEEP(sleep), .BOOT_GO(boot_go), .USE_REF_OSC(use_ref), .CRYSTAL_EN(xtal_en),
        .USE_EXT_SLOW_CLK(use_slow));
    // 10 MHz core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end
    // verdict in one place
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one comparison
    task automatic check(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            error_cnt++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    // pick an output by number
    function automatic logic pick(input int sel);
        case (sel)
            0: return chip_rst_n;
            1: return sleep;
            2: return clk_req;
            default: return boot_go;
        endcase
    endfunction
    // count falling edges until an output goes high, bounded
    task automatic wait_hi(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (pick(sel) !== 1'b1 && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
    endtask
    // common path from release to boot; called just after release is seen
    task automatic run_seq(input logic e_ref, input logic e_slow);
        int a, b;
        wait_hi(1, 4, a);
        check(a <= 2 && sleep === 1'b1, "sleep not entered after release");
        check(clk_req === 1'b0 && boot_go === 1'b0, "early request or boot");
        wait_hi(2, CLKREQ_CYC + 10, a);
        check(a >= CLKREQ_CYC - 1 && a <= CLKREQ_CYC + 2, "clock request timing");
        wait_hi(3, SLEEP_T + 10, b);
        check(a + b >= SLEEP_T && a + b <= SLEEP_T + 1, "sleep length");
        check(sleep === 1'b0 && clk_req === 1'b1, "sleep not left at boot");
        check(use_ref === e_ref && xtal_en === !e_ref, "reference or crystal pick");
        check(use_slow === e_slow, "slow clock pick");
    endtask
    // reset drop from a running state asserts reset and clears sleep, request and boot within a few cycles
    task automatic drop_check();
        wait_hi(0, 1, n);
        repeat (5) @(negedge clk);
        check(chip_rst_n === 1'b0 && sleep === 1'b0, "reset not taken");
        check(clk_req === 1'b0 && boot_go === 1'b0, "outputs not cleared");
    endtask
    // power-up path, both outside clocks fitted
    task automatic test_por_path();
        ref_on = 1'b1;
        slow_on = 1'b1;
        supply_on = 1'b1;
        wait_hi(0, POR_T + 10, n);
        check(n >= POR_T && n <= POR_T + 5, "power-up hold length");
        run_seq(1'b1, 1'b1);
    endtask
    // pin path: pin held far past the power-up hold, no outside clocks
    task automatic test_pin_path();
        int hi;
        pin_hold = 1'b1;
        ref_on = 1'b0;
        slow_on = 1'b0;
        drop_check();
        hi = 0;
        repeat (3 * POR_T) begin
            @(negedge clk);
            if (chip_rst_n !== 1'b0) hi++;
        end
        check(hi == 0, "released while pin held");
        pin_hold = 1'b0;
        wait_hi(0, 8, n);
        check(chip_rst_n === 1'b1 && n >= 2, "pin release timing");
        run_seq(1'b0, 1'b0);
    endtask
    // supply drop, pin freed early: the later power-up hold decides
    task automatic test_later_wins();
        supply_on = 1'b0;
        pin_hold = 1'b1;
        drop_check();
        ref_on = 1'b1;
        supply_on = 1'b1;
        repeat (10) @(negedge clk);
        pin_hold = 1'b0;
        wait_hi(0, POR_T + 10, n);
        check(n + 10 >= POR_T && n + 10 <= POR_T + 5, "later release wins");
        run_seq(1'b1, 1'b0);
    endtask
    // reset, then scenarios
    initial begin
        error_cnt = 0;
        total_checks = 0;
        arst_n = 1'b0;
        pin_hold = 1'b0;
        supply_on = 1'b0;
        ref_on = 1'b0;
        slow_on = 1'b0;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        check(chip_rst_n === 1'b0 && xtal_en === 1'b1, "reset state of outputs");
        test_por_path();
        test_pin_path();
        test_later_wins();
        stop_test();
    end
    // watchdog, well beyond three full sequences
    initial begin
        #(20000 * 100);
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
